/* File: sdpp_pkg.sv */
// Shared constants for the serial delay programming port
package sdpp_pkg;

    // Programming word layout
    localparam int unsigned WORD_W       = 11;
    localparam int unsigned CHSEL_POS    = 0;
    localparam int unsigned MODE_POS     = 1;
    localparam int unsigned CODE_LSB     = 2;
    localparam int unsigned CODE_W       = 9;
    localparam int unsigned CODE_MSB     = CODE_LSB + CODE_W - 1;
    localparam int unsigned CODE_STEPS   = 512;

    // Channel select encoding
    localparam logic        CHSEL_A      = 1'h0;
    localparam logic        CHSEL_B      = 1'h1;

    // Reset values of the shift register and latches
    localparam logic [WORD_W-1:0] WORD_RST = 11'h000;
    localparam logic [CODE_W-1:0] CODE_RST = 9'h000;

    // Synchroniser depth for every pin input
    localparam int unsigned SYNC_STAGES  = 2;

    // Serial clock limit, and shortest half period in system cycles
    localparam int unsigned CLK_PERIOD_NS  = 10;
    localparam int unsigned SCLK_MAX_MHZ   = 20;
    localparam int unsigned SCLK_HALF_NS   = 1000 / (2 * SCLK_MAX_MHZ);
    localparam int unsigned SCLK_HALF_CYC  =
        (SCLK_HALF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    // Routing mode held in the latch
    typedef enum logic [0:0] {
        SDPP_DUAL    = 1'b0,
        SDPP_CASCADE = 1'b1
    } sdpp_mode_e;

endpackage

/* File: sdpp_sync.sv */
// Two-stage synchroniser bank for asynchronous pin inputs
`timescale 1ns/1ps
module sdpp_sync #(
    parameter int unsigned WIDTH = 1
) (
    // Clock and reset
    input  wire logic             clk,
    input  wire logic             resetn,
    // Pins and synchronised copies
    input  wire logic [WIDTH-1:0] pin_in,
    output logic      [WIDTH-1:0] pin_sync
);
    import sdpp_pkg::*;

    logic [WIDTH-1:0] meta_ff;
    logic [WIDTH-1:0] sync_ff;

    // First stage feeds only the second stage
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            meta_ff <= '0;
            sync_ff <= '0;
        end else begin
            meta_ff <= pin_in;
            sync_ff <= meta_ff;
        end
    end

    assign pin_sync = sync_ff;

endmodule

/* File: sdpp_out_pair.sv */
// Registered differential output pair with a force-to-idle control
`timescale 1ns/1ps
module sdpp_out_pair (
    // Clock and reset
    input  wire logic clk,
    input  wire logic resetn,
    // Data and force control
    input  wire logic data_in,
    input  wire logic force_idle,
    // Output pair
    output logic      out_true,
    output logic      out_comp
);
    import sdpp_pkg::*;

    logic true_ff;
    logic comp_ff;

    // Idle state is true low, complement high
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            true_ff <= 1'b0;
            comp_ff <= 1'b1;
        end else begin
            true_ff <= force_idle ? 1'b0 : data_in;
            comp_ff <= force_idle ? 1'b1 : ~data_in;
        end
    end

    assign out_true = true_ff;
    assign out_comp = comp_ff;

endmodule

/* File: sdpp_top.sv */
// Serial programming port and output routing of a dual delay device
//
// Notes on behaviour
// RULE_01: An 11-bit shift register loads only from serial clock, data, strobe.
// RULE_02: A word is channel select, mode select, and a 9-bit delay code.
// RULE_03: Controller sends one full 11-bit load per channel; two after power-up.
// RULE_04: First bit lands in bit 0; 0 picks channel A, 1 channel B.
// RULE_05: Bit 1 is mode; upper nine bits are the code, MSB on top.
// RULE_06: Mode 0 routes input A to output A and input B to output B.
// RULE_07: Mode 1 routes input A through channel A then B to output B.
// RULE_08: In cascaded mode output pair A holds true low, complement high.
// RULE_09: The delay code is unsigned, one of 512 settings, 0 to 511.
// RULE_10: Each serial clock rising edge shifts in exactly one data bit.
// RULE_11: Strobe high makes the latch transparent; strobe falling freezes it.
// RULE_12: A closed latch ignores later serial data and serial clock activity.
// RULE_13: Channel steering and routing follow the loaded select and mode bits.
// RULE_14: Controller should raise the enable during programming, lower it after.
// RULE_15: Enable high forces true outputs low, complements high; programming works.
// RULE_16: Controller keeps the serial clock at or below 20 MHz, even duty.
// RULE_17: New bits enter at the top; extra clocks push oldest bits out.
// RULE_18: The unselected channel keeps its code across a load strobe.
`timescale 1ns/1ps
module sdpp_top (
    // Clock and reset
    input  wire logic                          clk,
    input  wire logic                          resetn,
    // Serial programming port pins
    input  wire logic                          serial_shift_clk,
    input  wire logic                          serial_data_in,
    input  wire logic                          latch_load_strobe,
    input  wire logic                          output_enable_n,
    // Signal inputs (true side of each pair)
    input  wire logic                          input_pair_a,
    input  wire logic                          input_pair_b,
    // Signal outputs
    output logic                               output_pair_a,
    output logic                               output_pair_a_n,
    output logic                               output_pair_b,
    output logic                               output_pair_b_n,
    // Latched settings for the delay lines, and the live shift register word
    output logic [sdpp_pkg::CODE_W-1:0]        delay_channel_a,
    output logic [sdpp_pkg::CODE_W-1:0]        delay_channel_b,
    output logic                               cascade_mode_bit,
    output logic [sdpp_pkg::WORD_W-1:0]        delay_program_word
);
    import sdpp_pkg::*;

    localparam int unsigned N_PINS = 6;

    // Channel select decode, shared by both latches
    function automatic logic chan_hit(input logic sel_bit, input logic chan);
        chan_hit = (sel_bit == chan);
    endfunction

    logic [N_PINS-1:0] pins_raw;
    logic [N_PINS-1:0] pins_s;
    logic              sclk_s;
    logic              serial_data_in_s;
    logic              load_s;
    logic              en_n_s;
    logic              in_a_s;
    logic              in_b_s;
    logic              sclk_last_ff;
    logic              sclk_rise;
    logic [WORD_W-1:0] shift_ff;
    logic [CODE_W-1:0] code_a_ff;
    logic [CODE_W-1:0] code_b_ff;
    sdpp_mode_e        mode_ff;
    logic              route_b_data;
    logic              force_a;

    // Every pin crosses two flops before any logic looks at it
    assign pins_raw = {input_pair_b, input_pair_a, output_enable_n,
                       latch_load_strobe, serial_data_in, serial_shift_clk};

    sdpp_sync #(
        .WIDTH (N_PINS)
    ) u_sync (
        .clk      (clk),
        .resetn   (resetn),
        .pin_in   (pins_raw),
        .pin_sync (pins_s)
    );

    assign sclk_s = pins_s[0];
    assign serial_data_in_s = pins_s[1];
    assign load_s = pins_s[2];
    assign en_n_s = pins_s[3];
    assign in_a_s = pins_s[4];
    assign in_b_s = pins_s[5];

    // Serial clock edge finder; clock and data share sync delay so
    // the bit sampled is the one present at the serial clock edge
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            sclk_last_ff <= 1'b0;
        end else begin
            sclk_last_ff <= sclk_s;
        end
    end

    assign sclk_rise = sclk_s & ~sclk_last_ff; // RULE_10

    // Shift register: one bit per serial clock rise, new bit at the top
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            shift_ff <= WORD_RST;
        end else if (sclk_rise) begin // RULE_01
            shift_ff <= {serial_data_in_s, shift_ff[WORD_W-1:1]}; // RULE_17
        end
    end

    // Channel A latch: transparent while the strobe is high
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            code_a_ff <= CODE_RST;
        end else if (load_s && chan_hit(shift_ff[CHSEL_POS], CHSEL_A)) begin
            code_a_ff <= shift_ff[CODE_MSB:CODE_LSB]; // RULE_04
        end
    end

    // Channel B latch: untouched when the word selects channel A
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            code_b_ff <= CODE_RST;
        end else if (load_s && chan_hit(shift_ff[CHSEL_POS], CHSEL_B)) begin
            code_b_ff <= shift_ff[CODE_MSB:CODE_LSB]; // RULE_18
        end
    end

    // Mode latch follows every load, whichever channel it targets
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            mode_ff <= SDPP_DUAL;
        end else if (load_s) begin // RULE_11
            mode_ff <= sdpp_mode_e'(shift_ff[MODE_POS]); // RULE_13
        end
    end

    // Routing: cascade sends input A on to output B and parks output A
    assign route_b_data = (mode_ff == SDPP_CASCADE) ? in_a_s : in_b_s; // RULE_07
    assign force_a      = en_n_s | (mode_ff == SDPP_CASCADE); // RULE_08

    // Output pairs; disable only masks outputs, programming goes on
    sdpp_out_pair u_out_a (
        .clk        (clk),
        .resetn     (resetn),
        .data_in    (in_a_s),
        .force_idle (force_a),
        .out_true   (output_pair_a),
        .out_comp   (output_pair_a_n)
    );

    sdpp_out_pair u_out_b (
        .clk        (clk),
        .resetn     (resetn),
        .data_in    (route_b_data),
        .force_idle (en_n_s), // RULE_15
        .out_true   (output_pair_b),
        .out_comp   (output_pair_b_n)
    );

    // Latched settings and the live shift register word straight from their flops
    assign delay_channel_a    = code_a_ff; // RULE_09
    assign delay_channel_b    = code_b_ff;
    assign cascade_mode_bit   = mode_ff;
    assign delay_program_word = shift_ff;

    // Named steps of a programming sequence
    sequence s_shift_edge;
        sclk_rise;
    endsequence

    sequence s_load_a;
        load_s && (shift_ff[CHSEL_POS] == CHSEL_A);
    endsequence

    sequence s_load_b;
        load_s && (shift_ff[CHSEL_POS] == CHSEL_B);
    endsequence

    sequence s_latch_closed;
        !load_s;
    endsequence

    // Outputs masked by the enable pin; programming must still go on
    sequence s_disabled;
        en_n_s;
    endsequence

    // Outputs live and the two paths independent
    sequence s_dual_live;
        !en_n_s && mode_ff == SDPP_DUAL;
    endsequence

    a_shift_advance: assert property (@(posedge clk) disable iff (!resetn)
        s_shift_edge
        |=> shift_ff == {$past(serial_data_in_s), $past(shift_ff[WORD_W-1:1])}) // RULE_10
        else $error("shift register did not take the serial bit");

    a_shift_hold: assert property (@(posedge clk) disable iff (!resetn)
        !sclk_rise |=> shift_ff == $past(shift_ff)) // RULE_01
        else $error("shift register moved without a serial clock edge");

    a_oldest_out: assert property (@(posedge clk) disable iff (!resetn)
        s_shift_edge |=> shift_ff[WORD_W-2:0] == $past(shift_ff[WORD_W-1:1])) // RULE_17
        else $error("older bits did not move toward bit 0");

    a_load_chan_a: assert property (@(posedge clk) disable iff (!resetn)
        s_load_a |=> code_a_ff == $past(shift_ff[CODE_MSB:CODE_LSB])) // RULE_04
        else $error("channel A code not taken from the word");

    a_load_chan_b: assert property (@(posedge clk) disable iff (!resetn)
        s_load_b |=> code_b_ff == $past(shift_ff[CODE_MSB:CODE_LSB])) // RULE_05
        else $error("channel B code not taken from the word");

    a_unsel_keep: assert property (@(posedge clk) disable iff (!resetn)
        s_load_a |=> $stable(code_b_ff)) // RULE_18
        else $error("unselected channel B changed on a load");

    a_unsel_keep_a: assert property (@(posedge clk) disable iff (!resetn)
        s_load_b |=> $stable(code_a_ff)) // RULE_18
        else $error("unselected channel A changed on a load");

    a_latch_frozen: assert property (@(posedge clk) disable iff (!resetn)
        s_latch_closed ##1 s_latch_closed
        |-> $stable(code_a_ff) && $stable(code_b_ff) && $stable(mode_ff)) // RULE_12
        else $error("closed latch changed");

    a_mode_steer: assert property (@(posedge clk) disable iff (!resetn)
        load_s |=> mode_ff == $past(shift_ff[MODE_POS])) // RULE_13
        else $error("mode latch does not follow the word");

    a_cascade_park: assert property (@(posedge clk) disable iff (!resetn)
        mode_ff == SDPP_CASCADE |=> !output_pair_a && output_pair_a_n) // RULE_08
        else $error("output pair A not parked in cascaded mode");

    a_disable_force: assert property (@(posedge clk) disable iff (!resetn)
        en_n_s |=> !output_pair_a && output_pair_a_n
                   && !output_pair_b && output_pair_b_n) // RULE_15
        else $error("disable did not force the outputs idle");

    a_dual_route: assert property (@(posedge clk) disable iff (!resetn)
        !en_n_s && mode_ff == SDPP_DUAL
        |=> output_pair_b == $past(in_b_s)
            && output_pair_a == $past(in_a_s)
            && output_pair_a_n == !$past(in_a_s)) // RULE_06
        else $error("dual mode routing wrong");

    a_cascade_route: assert property (@(posedge clk) disable iff (!resetn)
        !en_n_s && mode_ff == SDPP_CASCADE
        |=> output_pair_b == $past(in_a_s)
            && output_pair_b_n == !$past(in_a_s)) // RULE_07
        else $error("cascaded mode does not feed input A to output B");

    a_program_disabled: assert property (@(posedge clk) disable iff (!resetn)
        s_disabled and s_shift_edge
        |=> shift_ff[WORD_W-1] == $past(serial_data_in_s)) // RULE_15
        else $error("programming blocked while outputs disabled");

    // Each latch only moves in a cycle where the strobe was high; a
    // stray serial clock with the strobe low must leave it alone
    a_codes_closed: assert property ( // RULE_12
        @(posedge clk) disable iff (!resetn)
        s_latch_closed |=> $stable(code_a_ff) && $stable(code_b_ff))
        else $error("code latch moved with the strobe low");

    a_mode_closed: assert property ( // RULE_12
        @(posedge clk) disable iff (!resetn)
        s_latch_closed |=> $stable(mode_ff))
        else $error("mode latch moved with the strobe low");

    // Masking the outputs must not block a load
    a_disabled_load: assert property ( // RULE_15
        @(posedge clk) disable iff (!resetn)
        s_disabled and s_load_a
        |=> code_a_ff == $past(shift_ff[CODE_MSB:CODE_LSB]))
        else $error("load lost while outputs disabled");

    // Dual mode keeps pair B a true complement of input B
    a_dual_comp_b: assert property ( // RULE_06
        @(posedge clk) disable iff (!resetn)
        s_dual_live |=> output_pair_b_n == !$past(in_b_s))
        else $error("output pair B complement wrong in dual mode");

    // Pair A outputs stay complementary whenever dual mode is live
    a_dual_comp_a: assert property ( // RULE_06
        @(posedge clk) disable iff (!resetn)
        s_dual_live |=> output_pair_a_n == !output_pair_a)
        else $error("output pair A not complementary in dual mode");

    // Cascade path keeps pair B complementary as well
    a_cascade_comp_b: assert property ( // RULE_07
        @(posedge clk) disable iff (!resetn)
        !en_n_s && mode_ff == SDPP_CASCADE
        |=> output_pair_b_n == !output_pair_b)
        else $error("output pair B not complementary in cascade");

    // A channel B word sets code and mode from its own fields
    a_word_fields: assert property ( // RULE_02
        @(posedge clk) disable iff (!resetn)
        s_load_b
        |=> delay_channel_b == $past(shift_ff[CODE_MSB:CODE_LSB])
            && cascade_mode_bit == $past(shift_ff[MODE_POS]))
        else $error("word fields not split into code and mode");

    // The serial bit lands at the top of the word on every rise
    a_top_bit: assert property ( // RULE_10
        @(posedge clk) disable iff (!resetn)
        s_shift_edge |=> delay_program_word[WORD_W-1] == $past(serial_data_in_s))
        else $error("serial bit did not land at the top");

endmodule

/* File: sdpp_ctl_model.sv */
// Behavioural external controller driving the serial programming pins
`timescale 1ns/1ps
module sdpp_ctl_model (
    // Serial programming pins
    output logic serial_shift_clk,
    output logic serial_data_in,
    output logic latch_load_strobe
);
    // Half of a 125 ns serial clock, kept under the 20 MHz ceiling
    localparam realtime HALF = 62.5;

    // Clock stands still low outside frames
    initial begin
        serial_shift_clk = 1'b0;
        serial_data_in = 1'b0;
        latch_load_strobe = 1'b0;
    end

    // Bit 0 goes first; data moves only while the clock is low
    task automatic shift_bits(input logic [15:0] bits, input int n);
        for (int i = 0; i < n; i++) begin
            serial_data_in = bits[i];
            #(HALF);
            serial_shift_clk = 1'b1;
            #(HALF);
            serial_shift_clk = 1'b0;
        end
        // Released line shows the inverse so a stale bit cannot pass
        serial_data_in = ~serial_data_in;
    endtask

    // One strobe per finished word opens and then freezes the latch
    task automatic pulse_load();
        #(HALF);
        latch_load_strobe = 1'b1;
        #(HALF);
        latch_load_strobe = 1'b0;
    endtask
endmodule

/* File: sdpp_top_tb.sv */
// Self-checking bench for the serial delay programming port
`timescale 1ns/1ps
module sdpp_top_tb;
    import sdpp_pkg::*;
    logic              clk, resetn, sclk, serial_data_line, strobe, oen_n, in_a, in_b;
    logic              qa, qa_n, qb, qb_n, mode, exp_mode;
    logic [CODE_W-1:0] code_a, code_b, exp_a, exp_b;
    logic [WORD_W-1:0] word;
    logic [31:0]       rnd;
    logic [29:0]       c;
    logic [3:0]        oe;
    logic [15:0]       bits;
    logic [29:0]       cfg_q[$];
    logic [3:0]        out_q[$];
    event              cfg_ev, out_ev;
    int                errors, compares;

    sdpp_top i_dut (.clk(clk), .resetn(resetn), .serial_shift_clk(sclk),
        .serial_data_in(serial_data_line), .latch_load_strobe(strobe),
        .output_enable_n(oen_n), .input_pair_a(in_a), .input_pair_b(in_b),
        .output_pair_a(qa), .output_pair_a_n(qa_n), .output_pair_b(qb),
        .output_pair_b_n(qb_n), .delay_channel_a(code_a),
        .delay_channel_b(code_b), .cascade_mode_bit(mode),
        .delay_program_word(word));
    sdpp_ctl_model i_ctl (.serial_shift_clk(sclk), .serial_data_in(serial_data_line),
        .latch_load_strobe(strobe));

    // Free-running 100 MHz system clock
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction

    task automatic results();
        if (errors == 0 && compares > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    // Case equality keeps an unknown from passing as a match
    task automatic cmp_reg(input string n, input logic [10:0] e,
                           input logic [10:0] g);
        compares++;
        if (e !== g) begin
            errors++;
            $display("wrong value %s expected %h seen %h", n, e, g);
        end
    endtask

    task automatic cmp_out(input logic [3:0] e, input logic [3:0] g);
        compares++;
        if (e !== g) begin
            errors++;
            $display("wrong value outputs expected %h seen %h", e, g);
        end
    endtask

    // Waits past the three-edge latency before noting the settings
    task automatic note_cfg(input logic [WORD_W-1:0] w);
        repeat (8) @(posedge clk);
        #1;
        cfg_q.push_back({exp_b, exp_a, exp_mode, w});
        -> cfg_ev;
    endtask

    task automatic load(input logic ch, input logic md,
                        input logic [CODE_W-1:0] cd);
        logic [WORD_W-1:0] w;
        w = {cd, md, ch};
        i_ctl.shift_bits({5'h00, w}, WORD_W);
        i_ctl.pulse_load();
        if (ch == CHSEL_A) begin
            exp_a = cd;
        end else begin
            exp_b = cd;
        end
        exp_mode = md;
        note_cfg(w);
    endtask

    task automatic set_en(input logic v);
        @(posedge clk);
        oen_n <= v;
    endtask

    // Random pair inputs held long enough for enable and mode to settle
    task automatic pins(input int n);
        logic [3:0] x;
        repeat (n) begin
            rnd = lfsr(rnd);
            @(posedge clk);
            in_a <= rnd[0];
            in_b <= rnd[1];
            repeat (6) @(posedge clk);
            #1;
            x = {rnd[0], ~rnd[0], rnd[1], ~rnd[1]};
            if (exp_mode) begin
                x = {2'h1, rnd[0], ~rnd[0]};
            end
            if (oen_n) begin
                x = 4'h5;
            end
            out_q.push_back(x);
            -> out_ev;
        end
    endtask

    // Observers take the oldest note whenever a result is due
    always @(cfg_ev) begin
        c = cfg_q.pop_front();
        cmp_reg("word", c[10:0], word);
        cmp_reg("mode", {10'h000, c[11]}, {10'h000, mode});
        cmp_reg("code a", {2'h0, c[20:12]}, {2'h0, code_a});
        cmp_reg("code b", {2'h0, c[29:21]}, {2'h0, code_b});
    end

    always @(out_ev) begin
        oe = out_q.pop_front();
        cmp_out(oe, {qa, qa_n, qb, qb_n});
    end

    // Generous bound; the whole sequence needs about 11 us
    initial begin
        #200000;
        errors++;
        results();
    end

    initial begin
        rnd = 32'h5D1013DC;
        errors = 0;
        compares = 0;
        exp_a = CODE_RST;
        exp_b = CODE_RST;
        exp_mode = 1'b0;
        oen_n = 1'b1;
        in_a = 1'b0;
        in_b = 1'b0;
        resetn = 1'b0;
        repeat (8) @(posedge clk);
        resetn <= 1'b1;
        note_cfg(WORD_RST);
        pins(2);
        rnd = lfsr(rnd);
        load(CHSEL_A, 1'b0, rnd[12:4]);
        rnd = lfsr(rnd);
        load(CHSEL_B, 1'b0, rnd[12:4]);
        set_en(1'b0);
        pins(6);
        // Extra bits push the oldest out; closed latch ignores them
        bits = 16'h1A5B;
        i_ctl.shift_bits(bits, 13);
        note_cfg(bits[12:2]);
        load(CHSEL_A, 1'b1, 9'h1FF);
        pins(6);
        set_en(1'b1);
        pins(2);
        load(CHSEL_B, 1'b1, 9'h000);
        rnd = lfsr(rnd);
        load(CHSEL_B, 1'b0, rnd[12:4]);
        set_en(1'b0);
        pins(4);
        results();
    end
endmodule
